// ---- common/cssc_map.vh ----
// Purpose: Register map and constants for the clock source select block
// Assumes: 32-bit classic Wishbone, byte addresses, one register per word
// Notes:   Definitions only
`ifndef CSSC_MAP_VH
`define CSSC_MAP_VH

// Register byte offsets
`define CSSC_ADR_STATUS        8'h00
`define CSSC_ADR_CONFIG        8'h04
`define CSSC_ADR_MAX_VELOCITY  8'h08
`define CSSC_ADR_MAX_ACCEL     8'h0C
`define CSSC_ADR_ACTUAL_POS    8'h10
`define CSSC_ADR_STEP_PERIOD   8'h14
`define CSSC_ADR_CUR_VELOCITY  8'h18

// Status fields
`define CSSC_ST_EXT_SEL        0
`define CSSC_ST_SHORT_FLAG     1
`define CSSC_ST_DRV_ON         2

// Config fields
`define CSSC_CFG_SHORT_EN      0
`define CSSC_CFG_OFF_LSB       4
`define CSSC_CFG_OFF_MSB       7
`define CSSC_CFG_PWM_LSB       8
`define CSSC_CFG_PWM_MSB       9

// Field widths and reset values
`define CSSC_VEL_W             23
`define CSSC_ACC_W             16
`define CSSC_PERIOD_W          20
`define CSSC_CONFIG_RST        10'h050
`define CSSC_VEL_RST           23'h000000
`define CSSC_ACC_RST           16'h0000

// Internal oscillator model: tick rate = 20 MHz * NUM / DEN = 51118.08 Hz
`define CSSC_OSC_NUM           32'h004E0000
`define CSSC_OSC_DEN           32'h77359400
// Position phase accumulator: 16 fractional bits
`define CSSC_FRAC_W            16
// External clock prescaler width in bits: 256 pin edges per timing tick
`define CSSC_EXT_PRE_W         8
// Acceleration per tick is setting >> this shift, or 1 when a nonzero setting shifts to 0
`define CSSC_ACC_SHIFT         8

`endif

// ---- dv/cssc_assertions.sv ----
// Purpose: Port-level checks for the clock source select block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to cssc_top at the foot of this file
module cssc_assertions (
    input wire        mclk,
    input wire        rst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        ext_clk_in,
    input wire        step_in,
    input wire        drv_en_n,
    input wire        short_sense,
    input wire        ext_selected,
    input wire        short_flag,
    input wire        coil_hi,
    input wire        coil_lo,
    input wire        step_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Bus handshake
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    chk_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h20
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    // Source selection: only a pin rise selects, and it sticks
    chk_ext_pick: assert property (!ext_selected && ext_clk_in && !$past(ext_clk_in)
        |-> ##2 ext_selected) else $error("pin rise missed");
    chk_ext_cause: assert property ($rose(ext_selected) |-> $past(ext_clk_in, 2))
        else $error("selected without pin rise");
    chk_sel_hold: assert property (ext_selected |=> ext_selected) else $error("fell back to internal");
    // Short flag needs sense and enabled drivers, ticks or not
    chk_short_cause: assert property ($rose(short_flag) |-> $past(short_sense) && !$past(drv_en_n))
        else $error("short flag without cause");
    // Disabled drivers keep both coil outputs off
    chk_coil_off: assert property (drv_en_n [*3] |-> !coil_hi && !coil_lo) else $error("coil on while disabled");
    // A stopped external clock freezes chopper and stepping
    chk_clock_stop: assert property ((ext_selected && !ext_clk_in && $stable(drv_en_n)) [*6]
        |-> $stable(coil_hi) && $stable(coil_lo) && !step_out) else $error("activity without clock");
endmodule

bind cssc_top cssc_assertions cssc_assertions_i (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_clk_in(ext_clk_in), .step_in(step_in), .drv_en_n(drv_en_n),
    .short_sense(short_sense), .ext_selected(ext_selected), .short_flag(short_flag),
    .coil_hi(coil_hi), .coil_lo(coil_lo), .step_out(step_out));

// ---- dv/cssc_clk_src.sv ----
// Purpose: External clock source facing the clock pin
// Assumes: Clocked from the bench clock
// Notes:   Rests low when stopped, never left floating
module cssc_clk_src (
    input  wire  mclk,
    input  wire  run,
    output logic ext_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    initial ext_clk = 1'b0;
    // Half the bench rate gives 10 MHz at even duty
    always @(posedge mclk) begin
        ext_clk <= run ? ~ext_clk : 1'b0;
    end
endmodule

// ---- dv/cssc_top_tb.sv ----
// Purpose: Self-checking bench for the clock source select block
// Assumes: Wishbone slave acks one cycle after a request
// Notes:   Calibration interval shortened to keep the run brief
module cssc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, p1, p2, v1, per;
    logic        run = 1'b0, step_in = 1'b0, drv_en_n = 1'b1, short_sense = 1'b0;
    logic        ext_clk, ext_selected, short_flag, coil_hi, coil_lo, step_out;
    int          fails = 0, samples_checked = 0, cycles = 0;

    cssc_top cssc_top_i (
        .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_clk_in(ext_clk),
        .step_in(step_in), .drv_en_n(drv_en_n), .short_sense(short_sense), .ext_selected(ext_selected),
        .short_flag(short_flag), .coil_hi(coil_hi), .coil_lo(coil_lo), .step_out(step_out));
    cssc_clk_src cssc_clk_src_i (.mclk(mclk), .run(run), .ext_clk(ext_clk));

    // 20 MHz bench clock
    always #25 mclk = ~mclk;

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard, well above the planned run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fails++;
            $display("[ERR] t=%0t got=%h low=%h", $time, got, lo);
        end
    endtask

    // One classic cycle; data taken at the ack edge, released after it
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        {cyc, stb, we, sel, adr, wdat} <= {2'b11, wr, 4'hF, a, d};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        chk({31'h0, ack}, 32'h1);
        {cyc, stb} <= 2'b00;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rchk(8'h04, 32'h00000050);
        rchk(8'h14, 32'h000FFFFF);
        rchk(8'h20, 32'h00000000);
        rchk(8'h00, 32'h00000000);
        wr(8'h08, 32'h00002710);
        wr(8'h0C, 32'h0000EA60);
        repeat (18000) @(posedge mclk);
        rchk(8'h18, 32'h00002710);
        bus(1'b0, 8'h10, 32'h0, p1);
        repeat (40000) @(posedge mclk);
        bus(1'b0, 8'h10, 32'h0, p2);
        wr(8'h08, 32'h00000000);
        chk_in(p2 - p1, 32'h0000000F, 32'h00000010);
        // Scaler in thousandths: velocity times 2 ms interval over step count
        chk_in(32'd20000 / (p2 - p1), 32'd1250, 32'd1334);
        drv_en_n <= 1'b0;
        run <= 1'b1;
        repeat (4) @(posedge mclk);
        rchk(8'h00, 32'h00000005);
        repeat (1000) @(posedge mclk);
        // Two step rises 2050 cycles apart span four or five pin-clock ticks
        step_in <= 1'b1;
        repeat (2) @(posedge mclk);
        step_in <= 1'b0;
        repeat (2048) @(posedge mclk);
        step_in <= 1'b1;
        repeat (2) @(posedge mclk);
        step_in <= 1'b0;
        repeat (2) @(posedge mclk);
        bus(1'b0, 8'h14, 32'h0, per);
        chk_in(per, 32'h00000004, 32'h00000005);
        repeat (2900) @(posedge mclk);
        drv_en_n <= 1'b1;
        repeat (4) @(posedge mclk);
        run <= 1'b0;
        bus(1'b0, 8'h10, 32'h0, p1);
        bus(1'b0, 8'h18, 32'h0, v1);
        wr(8'h08, 32'h00400000);
        repeat (3000) @(posedge mclk);
        rchk(8'h18, v1);
        rchk(8'h10, p1);
        wr(8'h04, 32'h00000051);
        drv_en_n <= 1'b0;
        short_sense <= 1'b1;
        repeat (3) @(posedge mclk);
        short_sense <= 1'b0;
        rchk(8'h00, 32'h00000007);
        wr(8'h00, 32'h00000002);
        rchk(8'h00, 32'h00000005);
        conclude();
    end
endmodule

// ---- verilog/cssc_edge.v ----
// Purpose: Rising edge detector for a synchronous pin
// Assumes: Input already synchronous to mclk
// Notes:   Pulse is registered, one cycle after the edge
module cssc_edge (
    input  wire mclk,
    input  wire rst,
    input  wire din,
    output reg  rise
);
    reg prev_reg;

    // Remember last level, flag a low-to-high change
    always @(posedge mclk) begin
        if (rst) begin
            prev_reg <= 1'b0;
            rise     <= 1'b0;
        end else begin
            prev_reg <= din;
            rise     <= din & ~prev_reg;
        end
    end
endmodule

// ---- verilog/cssc_top.v ----
// Purpose: Clock source selection, timing tick and calibration aids
// Assumes: mclk 20 MHz; pins synchronous; classic Wishbone slave
// Notes:   Timing tick comes from the oscillator model or the clock pin
`include "cssc_map.vh"
module cssc_top (
    input  wire        mclk,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        ext_clk_in,
    input  wire        step_in,
    input  wire        drv_en_n,
    input  wire        short_sense,
    output reg         ext_selected,
    output reg         short_flag,
    output reg         coil_hi,
    output reg         coil_lo,
    output reg         step_out
);
    // Edge pulses from the clock and step pins
    wire ext_rise;
    wire step_rise;

    cssc_edge u_ext_edge (
        .mclk (mclk),
        .rst  (rst),
        .din  (ext_clk_in),
        .rise (ext_rise)
    );

    cssc_edge u_step_edge (
        .mclk (mclk),
        .rst  (rst),
        .din  (step_in),
        .rise (step_rise)
    );

    // Register file
    reg [9:0]                   config_reg;
    reg [`CSSC_VEL_W-1:0]       max_velocity_reg;
    reg [`CSSC_ACC_W-1:0]       max_accel_reg;
    reg [31:0]                  position_reg;
    reg [31:0]                  position_next;
    reg [`CSSC_VEL_W-1:0]       velocity_reg;
    reg [`CSSC_VEL_W-1:0]       velocity_next;
    reg [`CSSC_FRAC_W-1:0]      frac_reg;
    reg [`CSSC_PERIOD_W-1:0]    period_cnt_reg;
    reg [`CSSC_PERIOD_W-1:0]    step_period_reg;
    reg [31:0]                  osc_acc_reg;
    reg [31:0]                  osc_acc_next;
    reg                         int_tick_reg;
    reg [`CSSC_EXT_PRE_W-1:0]   ext_pre_reg;
    reg                         ext_tick_reg;
    reg [6:0]                   chop_cnt_reg;
    reg                         chop_phase_reg;

    // Bus decode
    wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        bus_wr   = bus_req & wb_we_i;
    wire [31:0] wr_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire        wr_cfg   = bus_wr & (wb_adr_i == `CSSC_ADR_CONFIG);
    wire        wr_max_velocity_setting  = bus_wr & (wb_adr_i == `CSSC_ADR_MAX_VELOCITY);
    wire        wr_max_acceleration_setting  = bus_wr & (wb_adr_i == `CSSC_ADR_MAX_ACCEL);
    wire        wr_pos   = bus_wr & (wb_adr_i == `CSSC_ADR_ACTUAL_POS);
    wire        wr_stat  = bus_wr & (wb_adr_i == `CSSC_ADR_STATUS);

    // Merge helper: keep old bits where byte lane is off
    wire [31:0] cfg_merged  = ({22'h000000, config_reg} & ~wr_mask) | (wb_dat_i & wr_mask);
    wire [31:0] max_velocity_setting_merged = ({9'h000, max_velocity_reg} & ~wr_mask) | (wb_dat_i & wr_mask);
    wire [31:0] max_acceleration_setting_merged = ({16'h0000, max_accel_reg} & ~wr_mask) | (wb_dat_i & wr_mask);
    wire [31:0] pos_merged  = (position_reg & ~wr_mask) | (wb_dat_i & wr_mask);

    // Selected timing tick; stops dead if the selected pin clock stops
    wire tick = ext_selected ? ext_tick_reg : int_tick_reg;

    wire drv_on = ~drv_en_n;

    // Source selection latches on first pin edge, cleared only by reset
    always @(posedge mclk) begin
        if (rst) begin
            ext_selected <= 1'b0;
        end else if (ext_rise) begin
            ext_selected <= 1'b1;
        end
    end

    // Oscillator model: fractional accumulator so the nominal rate is exact
    always @* begin
        osc_acc_next = osc_acc_reg + `CSSC_OSC_NUM;
        if (osc_acc_next >= `CSSC_OSC_DEN) begin
            osc_acc_next = osc_acc_next - `CSSC_OSC_DEN;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            osc_acc_reg  <= 32'h00000000;
            int_tick_reg <= 1'b0;
        end else begin
            osc_acc_reg  <= osc_acc_next;
            int_tick_reg <= (osc_acc_reg + `CSSC_OSC_NUM) >= `CSSC_OSC_DEN;
        end
    end

    // Pin clock prescaler; a silent pin yields no ticks at all
    always @(posedge mclk) begin
        if (rst) begin
            ext_pre_reg  <= {`CSSC_EXT_PRE_W{1'b0}};
            ext_tick_reg <= 1'b0;
        end else begin
            ext_tick_reg <= 1'b0;
            if (ext_rise) begin
                ext_pre_reg <= ext_pre_reg + 1'b1;
                if (&ext_pre_reg) begin
                    ext_tick_reg <= 1'b1;
                end
            end
        end
    end

    // Velocity ramp toward max velocity; zero setting brakes to a stop
    wire [`CSSC_VEL_W-1:0] acc_step_raw = {7'h00, max_accel_reg} >> `CSSC_ACC_SHIFT;
    wire [`CSSC_VEL_W-1:0] acc_step     = (acc_step_raw == {`CSSC_VEL_W{1'b0}} && max_accel_reg != 16'h0000)
                                          ? {{(`CSSC_VEL_W-1){1'b0}}, 1'b1} : acc_step_raw;

    always @* begin
        velocity_next = velocity_reg;
        if (velocity_reg < max_velocity_reg) begin
            if (max_velocity_reg - velocity_reg > acc_step) begin
                velocity_next = velocity_reg + acc_step;
            end else begin
                velocity_next = max_velocity_reg;
            end
        end else if (velocity_reg > max_velocity_reg) begin
            if (velocity_reg - max_velocity_reg > acc_step) begin
                velocity_next = velocity_reg - acc_step;
            end else begin
                velocity_next = max_velocity_reg;
            end
        end
    end

    // Position phase accumulator: steps per s = velocity * tick rate / 2^16
    wire [`CSSC_VEL_W:0] frac_sum = {{(`CSSC_VEL_W+1-`CSSC_FRAC_W){1'b0}}, frac_reg} + {1'b0, velocity_reg};
    wire [7:0]           step_adv = frac_sum[`CSSC_VEL_W:`CSSC_FRAC_W];

    always @* begin
        position_next = position_reg + {24'h000000, step_adv};
    end

    always @(posedge mclk) begin
        if (rst) begin
            velocity_reg <= `CSSC_VEL_RST;
            frac_reg     <= {`CSSC_FRAC_W{1'b0}};
            position_reg <= 32'h00000000;
            step_out     <= 1'b0;
        end else begin
            step_out <= 1'b0;
            if (wr_pos) begin
                position_reg <= pos_merged;
            end else if (tick) begin
                position_reg <= position_next;
                step_out     <= step_adv != 8'h00;
            end
            if (tick) begin
                velocity_reg <= velocity_next;
                frac_reg     <= frac_sum[`CSSC_FRAC_W-1:0];
            end
        end
    end

    // Step period in timing ticks between step pin edges, saturating
    always @(posedge mclk) begin
        if (rst) begin
            period_cnt_reg  <= {`CSSC_PERIOD_W{1'b0}};
            step_period_reg <= {`CSSC_PERIOD_W{1'b1}};
        end else begin
            if (step_rise) begin
                step_period_reg <= period_cnt_reg;
                period_cnt_reg  <= {`CSSC_PERIOD_W{1'b0}};
            end else if (tick && !(&period_cnt_reg)) begin
                period_cnt_reg <= period_cnt_reg + 1'b1;
            end
        end
    end

    // Chopper: half period set by off time and frequency select
    wire [3:0] off_time = config_reg[`CSSC_CFG_OFF_MSB:`CSSC_CFG_OFF_LSB];
    wire [1:0] pwm_sel  = config_reg[`CSSC_CFG_PWM_MSB:`CSSC_CFG_PWM_LSB];
    wire [6:0] chop_top = {1'b0, pwm_sel, off_time} + 7'h01;

    always @(posedge mclk) begin
        if (rst) begin
            chop_cnt_reg   <= 7'h00;
            chop_phase_reg <= 1'b0;
        end else if (tick) begin
            if (chop_cnt_reg >= chop_top) begin
                chop_cnt_reg   <= 7'h00;
                chop_phase_reg <= ~chop_phase_reg;
            end else begin
                chop_cnt_reg <= chop_cnt_reg + 7'h01;
            end
        end
    end

    // Bridge outputs; disabled drivers float both sides low
    always @(posedge mclk) begin
        if (rst) begin
            coil_hi <= 1'b0;
            coil_lo <= 1'b0;
        end else begin
            coil_hi <= drv_on & chop_phase_reg;
            coil_lo <= drv_on & ~chop_phase_reg;
        end
    end

    // Short detection runs on mclk, independent of the timing tick
    wire short_event = config_reg[`CSSC_CFG_SHORT_EN] & short_sense & drv_on;

    always @(posedge mclk) begin
        if (rst) begin
            short_flag <= 1'b0;
        end else if (short_event) begin
            short_flag <= 1'b1;
        end else if (wr_stat && wb_sel_i[0] && wb_dat_i[`CSSC_ST_SHORT_FLAG]) begin
            short_flag <= 1'b0;
        end
    end

    // Writable settings
    always @(posedge mclk) begin
        if (rst) begin
            config_reg       <= `CSSC_CONFIG_RST;
            max_velocity_reg <= `CSSC_VEL_RST;
            max_accel_reg    <= `CSSC_ACC_RST;
        end else begin
            if (wr_cfg) begin
                config_reg <= cfg_merged[9:0];
            end
            if (wr_max_velocity_setting) begin
                max_velocity_reg <= max_velocity_setting_merged[`CSSC_VEL_W-1:0];
            end
            if (wr_max_acceleration_setting) begin
                max_accel_reg <= max_acceleration_setting_merged[`CSSC_ACC_W-1:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    reg [31:0] rd_data;

    always @* begin
        case (wb_adr_i)
            `CSSC_ADR_STATUS:       rd_data = {29'h00000000, drv_on, short_flag, ext_selected};
            `CSSC_ADR_CONFIG:       rd_data = {22'h000000, config_reg};
            `CSSC_ADR_MAX_VELOCITY: rd_data = {9'h000, max_velocity_reg};
            `CSSC_ADR_MAX_ACCEL:    rd_data = {16'h0000, max_accel_reg};
            `CSSC_ADR_ACTUAL_POS:   rd_data = position_reg;
            `CSSC_ADR_STEP_PERIOD:  rd_data = {12'h000, step_period_reg};
            `CSSC_ADR_CUR_VELOCITY: rd_data = {9'h000, velocity_reg};
            default:                rd_data = 32'h00000000;
        endcase
    end

    // One wait state: ack and data registered together, ack drops next cycle
    always @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end
endmodule
